// >>> verilog/mpcl_mono_port.sv
// Our own choice: the APB slave port.
`timescale 1ns/1ps
module mpcl_mono_port
(
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic [mpcl_pkg::ADDR_W-1:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [mpcl_pkg::WORD_W-1:0] pwdata,
	output logic [mpcl_pkg::WORD_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic bclk,
	input wire logic lrclk,
	input wire logic mono_port_rx_pin,
	output logic mono_port_tx_pin,
	input wire logic alt_tx_in,
	output logic alt_rx_out,
	input wire logic [mpcl_pkg::WORD_W-1:0] tx_sample,
	input wire logic tx_valid,
	output logic tx_ready,
	output logic [mpcl_pkg::WORD_W-1:0] rx_sample,
	output logic rx_valid
);
	import mpcl_pkg::*;

	// ----------------------------------------------------------------
	// reference clock domain state
	// ----------------------------------------------------------------
	mpcl_ctrl_t ctrl_q, ctrl_d; // compand and loopback controls
	logic [1:0] wl_q, wl_d; // uncompanded word length
	logic alt_q, alt_d; // pins lent to the other ports
	logic [WORD_W-1:0] prdata_q, prdata_d; // read data, loaded at setup
	logic req_tgl_q, req_tgl_d; // flips when a tx word is posted
	logic [WORD_W-1:0] txw_q, txw_d; // posted tx word, held till ack
	logic ack_s1_q, ack_s2_q, ack_s3_q; // ack toggle synchroniser
	logic ack_acc_q, ack_acc_d; // ack level once stages agree
	logic rxt_s1_q, rxt_s2_q, rxt_s3_q; // rx toggle synchroniser
	logic rxt_acc_q, rxt_acc_d; // rx level once stages agree
	logic [WORD_W-1:0] rx_sample_q, rx_sample_d; // delivered sample
	logic rx_valid_q, rx_valid_d; // one cycle per delivered sample
	logic [7:0] rx_code_q, rx_code_d; // last raw companded code
	logic hit_ctrl1, hit_ctrl2, hit_stat; // address decode
	logic [15:0] tx_lin, rx_lin; // linear halves for the codecs
	logic [7:0] tx_code; // compressed transmit code
	mpcl_link_cfg_t cfg_ref; // settings as seen from this side

	// ----------------------------------------------------------------
	// bit clock domain state
	// ----------------------------------------------------------------
	logic rst_s1_q, rst_s2_q, rst_s3_q; // reset into the bit clock
	logic link_rst; // reset as the link logic sees it
	mpcl_link_cfg_t cfg_s1_q, cfg_s2_q, cfg_s3_q; // settings crossing
	mpcl_link_cfg_t cfg_q, cfg_d; // settings once stages agree
	logic req_s1_q, req_s2_q, req_s3_q; // request toggle crossing
	logic req_acc_q, req_acc_d; // also serves as the ack toggle
	logic [WORD_W-1:0] lw_q, lw_d; // word sent in the next slot
	logic lr_q, lr_d; // previous frame clock level
	logic [5:0] cnt_q, cnt_d; // bit position in slot, 0 when idle
	logic [WORD_W-1:0] tx_sh_q, tx_sh_d; // transmit shifter
	logic tx_bit_q, tx_bit_d; // bit on the transmit pin
	logic [WORD_W-1:0] rx_sh_q, rx_sh_d; // receive shifter
	logic [WORD_W-1:0] rx_word_q, rx_word_d; // last full received word
	logic rx_tgl_q, rx_tgl_d; // flips per received word
	logic in_bit; // receive input after the loopback mux
	logic [WORD_W-1:0] rx_next; // shifter with this edge's bit

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign prdata = prdata_q;
	assign pready = psel & penable;
	assign pslverr = psel & penable & ~(hit_ctrl1 | hit_ctrl2 | hit_stat);
	assign tx_ready = (ack_acc_q == req_tgl_q) & ~srst;
	assign rx_sample = rx_sample_q;
	assign rx_valid = rx_valid_q;
	// borrowed pins bypass the compander and loopback entirely
	assign mono_port_tx_pin = cfg_q.alt ? alt_tx_in : tx_bit_q;
	assign alt_rx_out = mono_port_rx_pin;
	assign link_rst = rst_s3_q;

	// ----------------------------------------------------------------
	// register file, transmit posting, receive delivery
	// ----------------------------------------------------------------

	// decode and companding helpers
	always_comb
	begin
		hit_ctrl1 = (paddr == mpcl_addr(REG_CTRL1_IDX));
		hit_ctrl2 = (paddr == mpcl_addr(REG_CTRL2_IDX));
		hit_stat = (paddr == mpcl_addr(REG_STAT_IDX));
		tx_lin = tx_sample[WORD_W-1:WORD_W-16];
		// law picks the segment table for each direction
		tx_code = ctrl_q.tx_compand_law ? mpcl_a_enc(tx_lin)
			: mpcl_mu_enc(tx_lin);
		rx_lin = ctrl_q.rx_compand_law
			? mpcl_a_dec(rx_word_q[WORD_W-1:WORD_W-8])
			: mpcl_mu_dec(rx_word_q[WORD_W-1:WORD_W-8]);
		cfg_ref.loop = ctrl_q.mono_port_loopback;
		cfg_ref.alt = alt_q;
		// companding is the only route to eight bit words
		cfg_ref.tx_len = ctrl_q.tx_compand_enable ? LEN_COMP
			: mpcl_wl_len(wl_q);
		cfg_ref.rx_len = ctrl_q.rx_compand_enable ? LEN_COMP
			: mpcl_wl_len(wl_q);
	end

	// next state of the reference domain
	always_comb
	begin
		ctrl_d = ctrl_q;
		wl_d = wl_q;
		alt_d = alt_q;
		prdata_d = prdata_q;
		req_tgl_d = req_tgl_q;
		txw_d = txw_q;
		ack_acc_d = ack_acc_q;
		rxt_acc_d = rxt_acc_q;
		rx_sample_d = rx_sample_q;
		rx_valid_d = 1'b0;
		rx_code_d = rx_code_q;
		// read data captured in setup so it comes from a flop
		if (psel && !penable)
		begin
			prdata_d = '0;
			if (hit_ctrl1)
			begin
				prdata_d[WL_LSB+:2] = wl_q;
				prdata_d[ROUTE_BIT] = alt_q;
			end
			else if (hit_ctrl2)
				prdata_d[RX_EN_BIT:LOOP_BIT] = ctrl_q;
			else if (hit_stat)
			begin
				prdata_d[STAT_RDY_BIT] = tx_ready;
				prdata_d[STAT_CODE_LSB+:8] = rx_code_q;
			end
		end
		// writes land in the access phase, no wait states
		if (psel && penable && pwrite)
		begin
			if (hit_ctrl1)
			begin
				wl_d = pwdata[WL_LSB+:2];
				alt_d = pwdata[ROUTE_BIT];
			end
			else if (hit_ctrl2)
			begin
				ctrl_d.rx_compand_enable = pwdata[RX_EN_BIT];
				ctrl_d.rx_compand_law = pwdata[RX_LAW_BIT];
				ctrl_d.tx_compand_enable = pwdata[TX_EN_BIT];
				ctrl_d.tx_compand_law = pwdata[TX_LAW_BIT];
				ctrl_d.mono_port_loopback = pwdata[LOOP_BIT];
			end
		end
		// a change counts only once stages two and three agree
		if (ack_s2_q == ack_s3_q)
			ack_acc_d = ack_s3_q;
		if (rxt_s2_q == rxt_s3_q)
			rxt_acc_d = rxt_s3_q;
		// post a tx word, the code goes out msb first
		if (tx_valid && tx_ready)
		begin
			txw_d = ctrl_q.tx_compand_enable
				? {tx_code, NO_FIELD, NO_FIELD, NO_FIELD} : tx_sample;
			req_tgl_d = ~req_tgl_q;
		end
		// rx word is stable until the next slot's word completes, safe to read
		if (rxt_acc_d != rxt_acc_q)
		begin
			rx_code_d = rx_word_q[WORD_W-1:WORD_W-8];
			rx_sample_d = ctrl_q.rx_compand_enable
				? {rx_lin, NO_FIELD, NO_FIELD} : rx_word_q;
			rx_valid_d = 1'b1;
		end
	end

	// reference domain registers
	always_ff @(posedge ref_clk)
	begin
		ack_s1_q <= req_acc_q;
		ack_s2_q <= ack_s1_q;
		ack_s3_q <= ack_s2_q;
		rxt_s1_q <= rx_tgl_q;
		rxt_s2_q <= rxt_s1_q;
		rxt_s3_q <= rxt_s2_q;
		if (srst)
		begin
			ctrl_q <= '0;
			wl_q <= WL_RST;
			alt_q <= 1'b0;
			prdata_q <= '0;
			req_tgl_q <= 1'b0;
			txw_q <= '0;
			ack_acc_q <= 1'b0;
			rxt_acc_q <= 1'b0;
			rx_sample_q <= '0;
			rx_valid_q <= 1'b0;
			rx_code_q <= '0;
		end
		else
		begin
			ctrl_q <= ctrl_d;
			wl_q <= wl_d;
			alt_q <= alt_d;
			prdata_q <= prdata_d;
			req_tgl_q <= req_tgl_d;
			txw_q <= txw_d;
			ack_acc_q <= ack_acc_d;
			rxt_acc_q <= rxt_acc_d;
			rx_sample_q <= rx_sample_d;
			rx_valid_q <= rx_valid_d;
			rx_code_q <= rx_code_d;
		end
	end

	// ----------------------------------------------------------------
	// bit clock side: left slot shifting and loopback
	// ----------------------------------------------------------------

	// next state of the link
	always_comb
	begin
		cfg_d = cfg_q;
		req_acc_d = req_acc_q;
		lw_d = lw_q;
		lr_d = lrclk;
		cnt_d = cnt_q;
		tx_sh_d = tx_sh_q;
		tx_bit_d = tx_bit_q;
		rx_sh_d = rx_sh_q;
		rx_word_d = rx_word_q;
		rx_tgl_d = rx_tgl_q;
		// settings are quasi static, taken once stages two and three agree
		if (cfg_s2_q == cfg_s3_q)
			cfg_d = cfg_s3_q;
		// loopback feeds our own tx bit, the pin is not looked at
		in_bit = (cfg_q.loop && !cfg_q.alt) ? tx_bit_q
			: mono_port_rx_pin;
		rx_next = {rx_sh_q[WORD_W-2:0], in_bit};
		// a new posted word is latched and acknowledged
		if (req_s2_q == req_s3_q && req_s3_q != req_acc_q)
		begin
			req_acc_d = req_s3_q;
			lw_d = txw_q;
		end
		// falling frame clock opens the left slot only
		if (lr_q && !lrclk)
		begin
			tx_bit_d = lw_q[WORD_W-1];
			tx_sh_d = lw_q << 1;
			cnt_d = 6'h01;
			rx_sh_d = '0;
		end
		else if (cnt_q != 6'h00)
		begin
			rx_sh_d = rx_next;
			if (cnt_q == cfg_q.rx_len)
			begin
				// left justify the word whatever its length
				rx_word_d = rx_next << (LEN_32 - cfg_q.rx_len);
				rx_tgl_d = ~rx_tgl_q;
			end
			if (cnt_q < cfg_q.tx_len)
			begin
				tx_bit_d = tx_sh_q[WORD_W-1];
				tx_sh_d = tx_sh_q << 1;
			end
			else
				tx_bit_d = 1'b0;
			// slot ends after the longer of the two words
			if (cnt_q >= cfg_q.tx_len && cnt_q >= cfg_q.rx_len)
				cnt_d = 6'h00;
			else
				cnt_d = cnt_q + 6'h01;
		end
	end

	// link registers; the bit clock may stop between frames
	always_ff @(posedge bclk)
	begin
		rst_s1_q <= srst;
		rst_s2_q <= rst_s1_q;
		rst_s3_q <= rst_s2_q;
		cfg_s1_q <= cfg_ref;
		cfg_s2_q <= cfg_s1_q;
		cfg_s3_q <= cfg_s2_q;
		req_s1_q <= req_tgl_q;
		req_s2_q <= req_s1_q;
		req_s3_q <= req_s2_q;
		if (link_rst)
		begin
			cfg_q <= '0;
			req_acc_q <= 1'b0;
			lw_q <= '0;
			lr_q <= 1'b0;
			cnt_q <= '0;
			tx_sh_q <= '0;
			tx_bit_q <= 1'b0;
			rx_sh_q <= '0;
			rx_word_q <= '0;
			rx_tgl_q <= 1'b0;
		end
		else
		begin
			cfg_q <= cfg_d;
			req_acc_q <= req_acc_d;
			lw_q <= lw_d;
			lr_q <= lr_d;
			cnt_q <= cnt_d;
			tx_sh_q <= tx_sh_d;
			tx_bit_q <= tx_bit_d;
			rx_sh_q <= rx_sh_d;
			rx_word_q <= rx_word_d;
			rx_tgl_q <= rx_tgl_d;
		end
	end

endmodule

// >>> verilog/mpcl_pkg.sv
// What this block does
// - receive companding enable, control bit 4
// - receive law select, bit 3, A-law
// - transmit companding enable, control bit 2
// - transmit law select, bit 1, A-law
// - loopback bit 0 feeds tx into rx
// - loopback ignores the external receive pin
// - controls act only on mono port path
// - companding carries 8-bit words, else word length
// - mono data sits in left slot
package mpcl_pkg;

	// ----------------------------------------------------------------
	// register map (word indices, byte address is four times)
	// ----------------------------------------------------------------
	localparam logic [11:0] REG_CTRL1_IDX = 12'h320; // word length, route
	localparam logic [11:0] REG_CTRL2_IDX = 12'h321; // compand, loopback
	localparam logic [11:0] REG_STAT_IDX = 12'h330; // live status
	localparam int ADDR_W = 32; // apb address width
	localparam int WORD_W = 32; // apb data and sample word width

	// ----------------------------------------------------------------
	// field positions and reset values
	// ----------------------------------------------------------------
	localparam int RX_EN_BIT = 4;
	localparam int RX_LAW_BIT = 3;
	localparam int TX_EN_BIT = 2;
	localparam int TX_LAW_BIT = 1;
	localparam int LOOP_BIT = 0;
	localparam int WL_LSB = 5; // two bit word length field
	localparam int ROUTE_BIT = 0; // pins lent to the other ports
	localparam int STAT_RDY_BIT = 0; // transmit word slot free
	localparam int STAT_CODE_LSB = 8; // last raw received code
	localparam logic [1:0] WL_RST = 2'h2; // 24 bits
	localparam logic [7:0] NO_FIELD = 8'h00; // reads of empty bits

	// ----------------------------------------------------------------
	// word lengths in bit clocks
	// ----------------------------------------------------------------
	localparam logic [5:0] LEN_COMP = 6'h08;
	localparam logic [5:0] LEN_16 = 6'h10;
	localparam logic [5:0] LEN_20 = 6'h14;
	localparam logic [5:0] LEN_24 = 6'h18;
	localparam logic [5:0] LEN_32 = 6'h20;

	// ----------------------------------------------------------------
	// companding constants
	// ----------------------------------------------------------------
	localparam logic [16:0] MU_CLIP = 17'h07F7B;
	localparam logic [15:0] MU_BIAS = 16'h0084;
	localparam logic [7:0] A_NEG_MASK = 8'h55;
	localparam logic [7:0] A_POS_MASK = 8'hD5;
	localparam logic [15:0] A_SEG0_ADD = 16'h0008;
	localparam logic [15:0] A_SEG_ADD = 16'h0108;

	// control bits as held by software
	typedef struct packed {
		logic rx_compand_enable;
		logic rx_compand_law;
		logic tx_compand_enable;
		logic tx_compand_law;
		logic mono_port_loopback;
	} mpcl_ctrl_t;

	// settings carried over into the bit clock domain
	typedef struct packed {
		logic loop;
		logic alt;
		logic [5:0] tx_len;
		logic [5:0] rx_len;
	} mpcl_link_cfg_t;

	// byte address of a register word
	function automatic logic [ADDR_W-1:0] mpcl_addr(input logic [11:0] idx);
		return {18'h00000, idx, 2'h0};
	endfunction

	// word length field to bit count
	function automatic logic [5:0] mpcl_wl_len(input logic [1:0] wl);
		case (wl)
			2'h0: return LEN_16;
			2'h1: return LEN_20;
			2'h2: return LEN_24;
			default: return LEN_32;
		endcase
	endfunction

	// mu-law compress, truncating inside the segment
	function automatic logic [7:0] mpcl_mu_enc(input logic [15:0] x);
		logic [16:0] mag;
		logic [2:0] ex;
		logic [16:0] sh;
		mag = x[15] ? (17'h00000 - {x[15], x}) : {1'b0, x};
		if (mag > MU_CLIP)
			mag = MU_CLIP;
		mag = mag + {1'b0, MU_BIAS};
		ex = 3'h0;
		for (int i = 0; i < 8; i++)
			if (mag[i + 7])
				ex = 3'(i);
		sh = mag >> ({2'h0, ex} + 5'h03);
		return ~{x[15], ex, sh[3:0]};
	endfunction

	// mu-law expand to 16-bit linear
	function automatic logic [15:0] mpcl_mu_dec(input logic [7:0] c);
		logic [7:0] u;
		logic [15:0] t;
		u = ~c;
		t = {9'h000, u[3:0], 3'h0} + MU_BIAS;
		t = t << u[6:4];
		return u[7] ? (MU_BIAS - t) : (t - MU_BIAS);
	endfunction

	// a-law compress from the top 13 bits
	function automatic logic [7:0] mpcl_a_enc(input logic [15:0] x);
		logic [12:0] p;
		logic [7:0] mask;
		logic [2:0] seg;
		logic [12:0] m;
		p = x[15:3];
		mask = x[15] ? A_NEG_MASK : A_POS_MASK;
		if (x[15])
			p = ~p;
		seg = 3'h0;
		for (int i = 0; i < 7; i++)
			if ((p >> (i + 5)) != 13'h0000)
				seg = 3'(i + 1);
		m = (seg < 3'h2) ? (p >> 1) : (p >> seg);
		return {1'b0, seg, m[3:0]} ^ mask;
	endfunction

	// a-law expand to 16-bit linear
	function automatic logic [15:0] mpcl_a_dec(input logic [7:0] c);
		logic [7:0] a;
		logic [15:0] t;
		a = c ^ A_NEG_MASK;
		t = {8'h00, a[3:0], 4'h0};
		if (a[6:4] == 3'h0)
			t = t + A_SEG0_ADD;
		else
			t = (t + A_SEG_ADD) << (a[6:4] - 3'h1);
		return a[7] ? t : (16'h0000 - t);
	endfunction

endpackage

// >>> sim/mpcl_mono_port_properties.sv
`timescale 1ns/1ps
// --------
// port checker for the mono port block
// --------
module mpcl_mono_port_properties
(
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic [mpcl_pkg::ADDR_W-1:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic [mpcl_pkg::WORD_W-1:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic mono_port_rx_pin,
	input wire logic alt_rx_out,
	input wire logic tx_valid,
	input wire logic tx_ready,
	input wire logic rx_valid
);
	import mpcl_pkg::*;
	default clocking @(posedge ref_clk);
	endclocking
	default disable iff (srst);
	// word accepted on the tx handshake
	sequence s_tx_take;
		tx_valid && tx_ready;
	endsequence
	property p_ready_acc;
		psel && penable |-> pready;
	endproperty
	a_ready_acc: assert property (p_ready_acc) else $error("no ready");
	property p_ready_idle;
		!(psel && penable) |-> !pready && !pslverr;
	endproperty
	a_ready_idle: assert property (p_ready_idle) else $error("idle ack");
	// the control register is mapped, never refused
	property p_ctrl_ok;
		psel && penable && paddr == {18'h00000, REG_CTRL2_IDX, 2'h0}
			|-> !pslverr;
	endproperty
	a_ctrl_ok: assert property (p_ctrl_ok) else $error("ctrl refused");
	property p_alt_rx;
		alt_rx_out == mono_port_rx_pin;
	endproperty
	a_alt_rx: assert property (p_alt_rx) else $error("alt rx differs");
	property p_rx_pulse;
		rx_valid |=> !rx_valid;
	endproperty
	a_rx_pulse: assert property (p_rx_pulse) else $error("long rx");
	// the ack has to cross the link twice, so ready stays low a while
	property p_tx_busy;
		s_tx_take |=> !tx_ready [*3];
	endproperty
	a_tx_busy: assert property (p_tx_busy) else $error("tx ready");
	property p_tx_fall;
		$fell(tx_ready) |-> $past(tx_valid);
	endproperty
	a_tx_fall: assert property (p_tx_fall) else $error("tx fall");
	// nothing is posted after reset, so the tx side is free at once
	property p_rst_quiet;
		$past(srst) |-> !rx_valid && tx_ready && prdata == 32'h0;
	endproperty
	a_rst_quiet: assert property (p_rst_quiet) else $error("reset");
endmodule
bind mpcl_mono_port mpcl_mono_port_properties mpcl_mono_port_properties_i
(
	.ref_clk(ref_clk), .srst(srst), .paddr(paddr), .psel(psel),
	.penable(penable), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .mono_port_rx_pin(mono_port_rx_pin),
	.alt_rx_out(alt_rx_out), .tx_valid(tx_valid), .tx_ready(tx_ready),
	.rx_valid(rx_valid)
);

// >>> sim/mpcl_pcm_host.sv
`timescale 1ns/1ps
// --------
// far-side pcm host: bit clock runs only inside frames
// --------
module mpcl_pcm_host
(
	output logic bclk,
	output logic lrclk,
	output logic mono_port_rx_pin,
	input wire logic mono_port_tx_pin
);
	initial
	begin
		bclk = 1'b0;
		lrclk = 1'b1;
		mono_port_rx_pin = 1'b0;
	end
	// one bit period, tx pin sampled late in the high phase
	task automatic tick(input logic d, output logic s);
		mono_port_rx_pin = d;
		#16 bclk = 1'b1;
		#15 s = mono_port_tx_pin;
		#1 bclk = 1'b0;
	endtask
	// one frame; garble toggles the rx pin instead of sending w
	task automatic frame(input logic [31:0] w, input bit garble,
		output logic [31:0] got);
		logic s;
		got = 32'h0;
		#7;
		repeat (8) tick(~mono_port_rx_pin, s);
		lrclk = 1'b0;
		tick(~mono_port_rx_pin, s);
		got[31] = s;
		for (int k = 1; k <= 32; k++)
		begin
			tick(garble ? ~mono_port_rx_pin : w[31], s);
			w = w << 1;
			if (k < 32)
				got[31 - k] = s;
		end
		lrclk = 1'b1;
		repeat (10) tick(~mono_port_rx_pin, s);
		// released line: never leave the last bit standing
		mono_port_rx_pin = ~mono_port_rx_pin;
	endtask
endmodule

// >>> sim/mpcl_mono_port_tb_top.sv
`timescale 1ns/1ps
module mpcl_mono_port_tb_top;
	import mpcl_pkg::*;
	// --------
	// bench signals
	// --------
	logic ref_clk, srst, psel, penable, pwrite, pready, pslverr;
	logic [ADDR_W-1:0] paddr;
	logic [WORD_W-1:0] pwdata, prdata, tx_sample, rx_sample;
	logic bclk, lrclk, mono_port_rx_pin, mono_port_tx_pin;
	logic alt_tx_in, alt_rx_out, tx_valid, tx_ready, rx_valid;
	logic [31:0] rx_words[$]; // words seen on rx_valid
	int err_total;
	int cmp_count;
	// companding table: linear in, code, linear back; mu then a-law
	logic [15:0] lin_t[4] = '{16'h0000, 16'h7FFF, 16'h8000, 16'h03E8};
	logic [7:0] code_t[8] = '{8'hFF, 8'h80, 8'h00, 8'hCE, 8'hD5, 8'hAA,
		8'h2A, 8'hFA};
	logic [15:0] back_t[8] = '{16'h0000, 16'h7D7C, 16'h8284, 16'h03DC,
		16'h0008, 16'h7E00, 16'h8200, 16'h03F0};
	mpcl_mono_port mpcl_mono_port_i
	(
		.ref_clk(ref_clk), .srst(srst), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .bclk(bclk),
		.lrclk(lrclk), .mono_port_rx_pin(mono_port_rx_pin),
		.mono_port_tx_pin(mono_port_tx_pin), .alt_tx_in(alt_tx_in),
		.alt_rx_out(alt_rx_out), .tx_sample(tx_sample),
		.tx_valid(tx_valid), .tx_ready(tx_ready), .rx_sample(rx_sample),
		.rx_valid(rx_valid)
	);
	mpcl_pcm_host mpcl_pcm_host_i
	(
		.bclk(bclk), .lrclk(lrclk), .mono_port_rx_pin(mono_port_rx_pin),
		.mono_port_tx_pin(mono_port_tx_pin)
	);
	initial
	begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end
	// rx_valid is a one-cycle pulse, so catch every one
	always @(posedge ref_clk)
		if (rx_valid === 1'b1)
			rx_words.push_back(rx_sample);
	// --------
	// tasks
	// --------
	task automatic chk(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		cmp_count++;
		if (got !== exp)
		begin
			err_total++;
			$display("unexpected %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// one apb transfer, held until pready is seen at an edge
	task automatic apb(input logic wr, input logic [11:0] idx,
		input logic [31:0] wd, output logic [31:0] rd, output logic err);
		int n;
		n = 0;
		@(posedge ref_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= {18'h00000, idx, 2'h0};
		pwrite <= wr;
		pwdata <= wd;
		@(posedge ref_clk);
		penable <= 1'b1;
		@(posedge ref_clk);
		// wait for the answer; only the watchdog ends a hung wait
		while (pready !== 1'b1)
		begin
			n++;
			@(posedge ref_clk);
		end
		chk("apb wait states", 32'h0, 32'(n));
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic reg_rd(input logic [11:0] idx, input logic [31:0] exp);
		logic [31:0] d;
		logic e;
		apb(1'b0, idx, 32'h0, d, e);
		chk("register", exp, d);
	endtask
	task automatic reg_wr(input logic [11:0] idx, input logic [31:0] wd);
		logic [31:0] d;
		logic e;
		apb(1'b1, idx, wd, d, e);
	endtask
	// post a tx word, run one frame, compare both directions
	task automatic xfer(input logic [31:0] tw, rw, input bit garble,
		input logic [31:0] etx, erx);
		logic [31:0] got;
		int n;
		n = 0;
		@(posedge ref_clk);
		while (tx_ready !== 1'b1 && n < 300)
		begin
			n++;
			@(posedge ref_clk);
		end
		chk("tx ready wait", 32'h0, {31'h0, n == 300});
		tx_sample <= tw;
		tx_valid <= 1'b1;
		@(posedge ref_clk);
		tx_valid <= 1'b0;
		mpcl_pcm_host_i.frame(rw, garble, got);
		chk("tx pin word", etx, got);
		n = 0;
		while (rx_words.size() == 0 && n < 100)
		begin
			n++;
			@(posedge ref_clk);
		end
		got = (n < 100) ? rx_words.pop_front() : 32'hXXXXXXXX;
		chk("rx sample", erx, got);
	endtask
	// --------
	// main sequence
	// --------
	initial
	begin
		logic [31:0] t, m, got;
		logic e;
		void'($urandom(32'hA73F));
		err_total = 0;
		cmp_count = 0;
		srst = 1'b1;
		{psel, penable, pwrite, tx_valid, alt_tx_in} = 5'h00;
		paddr = 32'h0;
		pwdata = 32'h0;
		tx_sample = 32'h0;
		// link side resets through a sync, so bclk runs during reset
		fork
			mpcl_pcm_host_i.frame(32'h0, 1'b0, got);
			begin
				repeat (5) @(posedge ref_clk);
				srst <= 1'b0;
			end
		join
		rx_words.delete();
		reg_rd(REG_CTRL2_IDX, 32'h0);
		reg_rd(REG_CTRL1_IDX, 32'h40);
		apb(1'b0, 12'h3FF, 32'h0, t, e);
		chk("unmapped", 32'h1, {31'h0, e});
		t = $urandom;
		reg_wr(REG_CTRL2_IDX, t);
		reg_rd(REG_CTRL2_IDX, t & 32'h1F);
		reg_wr(REG_CTRL2_IDX, 32'h0);
		for (int wl = 0; wl < 4; wl++)
		begin
			reg_wr(REG_CTRL1_IDX, 32'(wl) << 5);
			m = ~(32'hFFFFFFFF >> (wl == 3 ? 32 : 16 + 4 * wl));
			t = $urandom;
			got = $urandom;
			xfer(t, got, 1'b0, t & m, got & m);
		end
		reg_wr(REG_CTRL2_IDX, 32'h1);
		t = $urandom;
		xfer(t, $urandom, 1'b1, t, t);
		for (int lp = 0; lp < 2; lp++)
			for (int i = 0; i < 8; i++)
			begin
				reg_wr(REG_CTRL2_IDX, {27'h0, 1'b1, i > 3, 1'b1, i > 3, lp[0]});
				xfer({lin_t[i % 4], 16'($urandom)},
					{code_t[i], 24'($urandom)}, lp[0], {code_t[i], 24'h0},
					{back_t[i], 16'h0});
			end
		// last word was the looped a-law code, tx side idle again
		reg_rd(REG_STAT_IDX, {16'h0, code_t[7], 8'h01});
		// the route only reaches the link while its bit clock runs
		reg_wr(REG_CTRL1_IDX, 32'h61);
		alt_tx_in <= 1'b1;
		mpcl_pcm_host_i.frame(32'h0, 1'b0, got);
		chk("routed frame", 32'hFFFFFFFF, got);
		@(posedge ref_clk);
		for (int b = 0; b < 2; b++)
		begin
			alt_tx_in <= b[0];
			repeat (2) @(posedge ref_clk);
			chk("routed tx", {31'h0, b[0]}, {31'h0, mono_port_tx_pin});
		end
		end_sim();
	end
	// watchdog against a hung handshake
	initial
	begin
		repeat (20000) @(posedge ref_clk);
		err_total++;
		$display("unexpected watchdog expiry");
		end_sim();
	end
endmodule
